// ===== hw/mprb_top.sv
// mprb_top: emits the page descriptor part of mode sense data, byte by byte.
// assumes an outside value store answering rd_data_in in the same cycle and
// a byte sink with valid/ready; all inputs synchronous to mclk_in.
// Notes on behaviour
// - each page opens with savable flag, zero bit, six-bit code, then length byte
// - length byte counts the page's parameter bytes; zero is allowed
// - ten page codes supported; other codes reserved, 21h to 3eh silently ignored
// - code 3fh returns every supported page in the selected value set
// - selector sits in bits 7:6 of byte 2: live, mask, default, saved
// - selector 00 fills every field with current values
// - other codes return only that one page, and only if supported
// - current values: last mode select, else saved if present, else defaults
// - unsupported fields read zero; lengths reflect supported fields
// - selector 01 returns masks of initiator-changeable bits
// - mask page without changeable bits is just its two header bytes
// - selector 10 returns default values, unsupported fields zero
// - selector 11 returns saved values, or defaults when saving absent
// - stop at allocation length or end of data; zero sends nothing
`timescale 1ns/1ps
`default_nettype none
module mprb_top (
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_b_in,
	// command
	input  wire logic        start_in,
	input  wire logic [7:0]  cdb_byte2_in,
	input  wire logic [7:0]  alloc_len_in,
	// value state
	input  wire logic        mode_select_ok_in,
	input  wire logic        saving_avail_in,
	input  wire logic        saved_valid_in,
	input  wire logic [9:0]  page_savable_in,
	// value store read
	output logic      [5:0]  rd_page_out,
	output logic      [4:0]  rd_offset_out,
	output logic      [1:0]  rd_bank_out,
	input  wire logic [7:0]  rd_data_in,
	// data-in byte stream
	output logic      [7:0]  data_out,
	output logic             data_valid_out,
	input  wire logic        data_ready_in,
	// status
	output logic             busy_out,
	output logic             done_out,
	output logic             reserved_page_out
);
	// reset release through two flops
	logic rst_s1_q, rst_n;
	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in) {rst_n, rst_s1_q} <= 2'b00;
		else {rst_n, rst_s1_q} <= {rst_s1_q, 1'b1};
	end

	mprb_pkg::mprb_state_e st_q, st_d;
	logic [3:0] idx_q, idx_d;
	logic [4:0] off_q, off_d;
	logic [7:0] alloc_q, alloc_d, sent_q, sent_d, data_q, data_d;
	logic       all_q, all_d, mask_q, mask_d, vld_q, vld_d;
	logic       rsv_q, rsv_d, done_q, done_d, ms_done_q;
	logic [1:0] bank_q, bank_d;

	// command decode
	wire [1:0] sel_w  = cdb_byte2_in[mprb_pkg::SEL_HI:mprb_pkg::SEL_LO];
	wire [5:0] code_w = cdb_byte2_in[5:0];
	wire       req_all_w = code_w == mprb_pkg::CODE_ALL;
	wire       ign_w = code_w >= mprb_pkg::IGN_LO && code_w <= mprb_pkg::IGN_HI;
	wire       sav_ok_w = saving_avail_in && saved_valid_in;
	logic [9:0] hit_w;
	logic [3:0] hit_idx_w;
	genvar g;
	for (g = 0; g < mprb_pkg::NPG; g++)
	begin : g_hit
		assign hit_w[g] = code_w == mprb_pkg::PG_CODE[g];
	end
	always_comb
	begin
		hit_idx_w = mprb_pkg::IDX_ZERO;
		for (int i = 0; i < mprb_pkg::NPG; i++)
			if (hit_w[i]) hit_idx_w = 4'(i);
	end

	// value bank choice; live bank only once a mode select has landed
	logic [1:0] bank_w;
	always_comb
	begin
		case (sel_w)
			mprb_pkg::SEL_LIVE: bank_w = ms_done_q ? mprb_pkg::BANK_LIVE :
				(sav_ok_w ? mprb_pkg::BANK_SAVE : mprb_pkg::BANK_DFLT);
			mprb_pkg::SEL_MASK: bank_w = mprb_pkg::BANK_MASK;
			mprb_pkg::SEL_DFLT: bank_w = mprb_pkg::BANK_DFLT;
			default: bank_w = sav_ok_w ? mprb_pkg::BANK_SAVE : mprb_pkg::BANK_DFLT;
		endcase
	end

	// current page view; mask lengths are zero for pages with nothing changeable
	wire [7:0] cur_len_w = mask_q ? mprb_pkg::LEN_MASK[idx_q] : mprb_pkg::LEN_VAL[idx_q];
	wire [5:0] cur_code_w = mprb_pkg::PG_CODE[idx_q];
	wire       room_w = sent_q != alloc_q;
	wire       take_w = !vld_q || data_ready_in;
	wire       in_pg_w = st_q == mprb_pkg::ST_HDR0 || st_q == mprb_pkg::ST_HDR1 || st_q == mprb_pkg::ST_BODY;
	wire       emit_w = in_pg_w && take_w && room_w;
	wire       last_pg_w = !all_q || idx_q == mprb_pkg::LAST_IDX;
	wire       body_end_w = {3'b000, off_q} == cur_len_w - 8'h01;
	wire [7:0] hdr0_w = {page_savable_in[idx_q], 1'b0, cur_code_w};
	// byte selection
	wire [7:0] byte_w = st_q == mprb_pkg::ST_HDR0 ? hdr0_w :
		(st_q == mprb_pkg::ST_HDR1 ? cur_len_w : rd_data_in);

	// sequencer next state
	always_comb
	begin
		st_d = st_q;
		idx_d = idx_q;
		off_d = off_q;
		alloc_d = alloc_q;
		all_d = all_q;
		mask_d = mask_q;
		bank_d = bank_q;
		rsv_d = rsv_q;
		done_d = 1'b0;
		case (st_q)
			mprb_pkg::ST_IDLE:
				if (start_in)
				begin
					alloc_d = alloc_len_in;
					all_d = req_all_w;
					mask_d = sel_w == mprb_pkg::SEL_MASK;
					bank_d = bank_w;
					rsv_d = !req_all_w && hit_w == 10'h000 && !ign_w;
					idx_d = req_all_w ? mprb_pkg::IDX_ZERO : hit_idx_w;
					off_d = mprb_pkg::OFF_RST;
					if (alloc_len_in == 8'h00 || (!req_all_w && hit_w == 10'h000))
						st_d = mprb_pkg::ST_FIN;
					else
						st_d = mprb_pkg::ST_HDR0;
				end
			mprb_pkg::ST_HDR0, mprb_pkg::ST_HDR1, mprb_pkg::ST_BODY:
				if (!room_w)
					st_d = mprb_pkg::ST_FIN;
				else if (emit_w)
				begin
					if (st_q == mprb_pkg::ST_HDR0)
						st_d = mprb_pkg::ST_HDR1;
					else if (st_q == mprb_pkg::ST_HDR1 && cur_len_w != 8'h00)
					begin
						st_d = mprb_pkg::ST_BODY;
						off_d = mprb_pkg::OFF_RST;
					end
					else if (st_q == mprb_pkg::ST_BODY && !body_end_w)
						off_d = off_q + 5'h01;
					else if (last_pg_w)
						st_d = mprb_pkg::ST_FIN;
					else
					begin
						idx_d = idx_q + 4'h1;
						st_d = mprb_pkg::ST_HDR0;
					end
				end
			mprb_pkg::ST_FIN:
				if (take_w)
				begin
					st_d = mprb_pkg::ST_IDLE;
					done_d = 1'b1;
				end
			default: st_d = mprb_pkg::ST_IDLE;
		endcase
	end

	// output byte register; holds while the sink stalls
	assign sent_d = st_q == mprb_pkg::ST_IDLE ? 8'h00 : sent_q + {7'h00, emit_w};
	assign vld_d = emit_w | (vld_q & ~data_ready_in);
	assign data_d = emit_w ? byte_w : data_q;

	// sequencer registers
	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= mprb_pkg::ST_IDLE;
			idx_q <= mprb_pkg::IDX_ZERO;
			off_q <= mprb_pkg::OFF_RST;
			{alloc_q, sent_q, data_q} <= {3{mprb_pkg::BYTE_RST}};
			{all_q, mask_q, vld_q, rsv_q, done_q} <= 5'h00;
			bank_q <= mprb_pkg::BANK_DFLT;
		end
		else
		begin
			st_q <= st_d;
			idx_q <= idx_d;
			off_q <= off_d;
			{alloc_q, sent_q, data_q} <= {alloc_d, sent_d, data_d};
			{all_q, mask_q, vld_q, rsv_q, done_q} <= {all_d, mask_d, vld_d, rsv_d, done_d};
			bank_q <= bank_d;
		end
	end

	// mode select seen since power-on; only reset clears it
	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n) ms_done_q <= 1'b0;
		else if (mode_select_ok_in) ms_done_q <= 1'b1;
	end

	// outputs
	assign rd_page_out = cur_code_w;
	assign rd_offset_out = off_q;
	assign rd_bank_out = bank_q;
	assign data_out = data_q;
	assign data_valid_out = vld_q;
	assign busy_out = st_q != mprb_pkg::ST_IDLE;
	assign done_out = done_q;
	assign reserved_page_out = rsv_q;

	// checks
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n);
	wire idle_start_w = start_in && st_q == mprb_pkg::ST_IDLE;

	property p_hdr0;
		emit_w && st_q == mprb_pkg::ST_HDR0 |=> data_out[mprb_pkg::HDR_ZERO_BIT] == 1'b0
			&& data_out[5:0] == $past(cur_code_w) && data_valid_out;
	endproperty
	a_hdr0: assert property (p_hdr0)
		else $error("page header byte 0 wrong");
	property p_len;
		emit_w && st_q == mprb_pkg::ST_HDR1 |=> data_out == $past(cur_len_w);
	endproperty
	a_len: assert property (p_len)
		else $error("page length byte wrong");
	property p_ignored;
		idle_start_w && ign_w |=> st_q == mprb_pkg::ST_FIN && !reserved_page_out;
	endproperty
	a_ignored: assert property (p_ignored)
		else $error("ignored code not skipped");
	property p_next_page;
		emit_w && all_q && st_q == mprb_pkg::ST_HDR1 && cur_len_w == 8'h00
			&& idx_q != mprb_pkg::LAST_IDX |=> idx_q == $past(idx_q) + 4'h1 && st_q == mprb_pkg::ST_HDR0;
	endproperty
	a_next_page: assert property (p_next_page)
		else $error("all-pages walk skipped");
	property p_bank_mask;
		idle_start_w && sel_w == mprb_pkg::SEL_MASK |=> rd_bank_out == mprb_pkg::BANK_MASK;
	endproperty
	a_bank_mask: assert property (p_bank_mask)
		else $error("mask bank not chosen");
	property p_live;
		idle_start_w && sel_w == mprb_pkg::SEL_LIVE && !ms_done_q && sav_ok_w
			|=> rd_bank_out == mprb_pkg::BANK_SAVE;
	endproperty
	a_live: assert property (p_live)
		else $error("current values source wrong");
	property p_saved;
		idle_start_w && sel_w == mprb_pkg::SEL_SAVE && !saving_avail_in |=> rd_bank_out == mprb_pkg::BANK_DFLT;
	endproperty
	a_saved: assert property (p_saved)
		else $error("saved request without saving");
	property p_single;
		emit_w && !all_q && st_q == mprb_pkg::ST_BODY && body_end_w |=> st_q == mprb_pkg::ST_FIN;
	endproperty
	a_single: assert property (p_single)
		else $error("single page overran");
	property p_alloc;
		idle_start_w && alloc_len_in == 8'h00 |=> !data_valid_out [*2];
	endproperty
	a_alloc: assert property (p_alloc)
		else $error("allocation length exceeded");
	// the byte counter must never pass the allocation, or the host buffer overflows
	property p_sent_bound;
		busy_out |-> sent_q <= alloc_q;
	endproperty
	a_sent_bound: assert property (p_sent_bound)
		else $error("more bytes than allocated");
	// a stalled byte must stand, otherwise the stream loses or repeats bytes
	property p_hold;
		data_valid_out && !data_ready_in |=> data_valid_out && data_out == $past(data_out);
	endproperty
	a_hold: assert property (p_hold)
		else $error("stalled byte not held");
	property p_body;
		emit_w && st_q == mprb_pkg::ST_BODY |=> data_out == $past(rd_data_in) && data_valid_out;
	endproperty
	a_body: assert property (p_body)
		else $error("parameter byte not from store");
	property p_reserved;
		idle_start_w && !req_all_w && hit_w == 10'h000 && !ign_w |=> reserved_page_out && st_q == mprb_pkg::ST_FIN;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved code not flagged");
	property p_dflt;
		idle_start_w && sel_w == mprb_pkg::SEL_DFLT |=> rd_bank_out == mprb_pkg::BANK_DFLT;
	endproperty
	a_dflt: assert property (p_dflt)
		else $error("default bank not chosen");
	property p_live_ms;
		idle_start_w && sel_w == mprb_pkg::SEL_LIVE && ms_done_q |=> rd_bank_out == mprb_pkg::BANK_LIVE;
	endproperty
	a_live_ms: assert property (p_live_ms)
		else $error("live bank not chosen after mode select");
	property p_empty_mask;
		emit_w && mask_q && st_q == mprb_pkg::ST_HDR1 && cur_len_w == 8'h00 |=> st_q != mprb_pkg::ST_BODY;
	endproperty
	a_empty_mask: assert property (p_empty_mask)
		else $error("empty mask page has body");

	c_all: cover property (idle_start_w && req_all_w ##[1:300] done_out);
	c_mask_empty: cover property (mask_q && st_q == mprb_pkg::ST_HDR1 && cur_len_w == 8'h00 && emit_w);
	c_cut: cover property (in_pg_w && !room_w);
	c_stall: cover property (data_valid_out && !data_ready_in ##1 data_valid_out);
endmodule : mprb_top
`default_nettype wire

// ===== hw/mprb_pkg.sv
// mprb_pkg: constants, page map and state codes of the mode page report builder.
// assumes a single 50 MHz clock domain; no timing counts are needed.
`default_nettype none
package mprb_pkg;
	// supported pages, ascending code order
	localparam int         NPG      = 10;
	localparam logic [3:0] LAST_IDX = 4'h9;
	localparam logic [3:0] IDX_ZERO = 4'h0;
	localparam logic [5:0] PG_CODE [NPG] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04,
		6'h08, 6'h0a, 6'h0c, 6'h1a, 6'h20};
	// parameter bytes per page for live, default and saved sets
	localparam logic [7:0] LEN_VAL [NPG] = '{8'h03, 8'h0a, 8'h0e, 8'h16, 8'h16,
		8'h0a, 8'h06, 8'h16, 8'h0a, 8'h18};
	// parameter bytes per page for the changeable mask set
	localparam logic [7:0] LEN_MASK [NPG] = '{8'h03, 8'h0a, 8'h0e, 8'h00, 8'h00,
		8'h0a, 8'h06, 8'h06, 8'h0a, 8'h18};
	// page code and selector fields of command byte 2
	localparam logic [5:0] CODE_ALL = 6'h3f;
	localparam logic [5:0] IGN_LO   = 6'h21;
	localparam logic [5:0] IGN_HI   = 6'h3e;
	localparam int         SEL_HI   = 7;
	localparam int         SEL_LO   = 6;
	// header byte 0 layout
	localparam int         HDR_SAVE_BIT = 7;
	localparam int         HDR_ZERO_BIT = 6;
	// page_value_selector encodings
	localparam logic [1:0] SEL_LIVE = 2'h0;
	localparam logic [1:0] SEL_MASK = 2'h1;
	localparam logic [1:0] SEL_DFLT = 2'h2;
	localparam logic [1:0] SEL_SAVE = 2'h3;
	// value store banks
	localparam logic [1:0] BANK_LIVE = 2'h0;
	localparam logic [1:0] BANK_MASK = 2'h1;
	localparam logic [1:0] BANK_DFLT = 2'h2;
	localparam logic [1:0] BANK_SAVE = 2'h3;
	// reset values
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [4:0] OFF_RST  = 5'h00;
	// report sequencer states
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_HDR0 = 5'h02,
		ST_HDR1 = 5'h04,
		ST_BODY = 5'h08,
		ST_FIN  = 5'h10
	} mprb_state_e;
endpackage : mprb_pkg
`default_nettype wire

// ===== verif/mprb_store_model.sv
// mprb_store_model: value store partner that answers every read in the same cycle.
// assumes the builder holds page, offset and bank steady while a byte is read.
`timescale 1ns/1ps
`default_nettype none
module mprb_store_model (
	// read request
	input  wire logic [5:0] page_in,
	input  wire logic [4:0] offset_in,
	input  wire logic [1:0] bank_in,
	// read answer
	output logic      [7:0] data_out
);
	// bank, offset and page all fold in, so a wrong bank or page shows as a wrong byte
	assign data_out = {bank_in, 1'b0, offset_in} ^ {page_in, 2'h0};
endmodule : mprb_store_model
`default_nettype wire

// ===== verif/mprb_top_tb.sv
// mprb_top_tb: self-checking bench for the mode page report builder.
// assumes the store model answers reads combinationally; the byte sink is driven here.
`timescale 1ns/1ps
`default_nettype none
module mprb_top_tb;
	logic       mclk_in = 1'b0;
	logic       rst_b_in = 1'b0;
	logic       start_in = 1'b0;
	logic [7:0] cdb_byte2_in = 8'h00;
	logic [7:0] alloc_len_in = 8'h00;
	logic       mode_select_ok_in = 1'b0;
	logic       saving_avail_in = 1'b0;
	logic       saved_valid_in = 1'b0;
	logic [9:0] page_savable_in = 10'h2a5;
	logic       data_ready_in = 1'b1;
	logic [5:0] rd_page_out;
	logic [4:0] rd_offset_out;
	logic [1:0] rd_bank_out;
	logic [7:0] rd_data_in;
	logic [7:0] data_out;
	logic       data_valid_out;
	logic       busy_out;
	logic       done_out;
	logic       reserved_page_out;
	int         errors = 0;
	int         checked = 0;
	bit         ms_seen = 1'b0;
	bit         stall = 1'b0;
	logic [7:0] got[$];
	logic [7:0] exp[$];

	mprb_top uut (.mclk_in, .rst_b_in, .start_in, .cdb_byte2_in, .alloc_len_in, .mode_select_ok_in,
		.saving_avail_in, .saved_valid_in, .page_savable_in, .rd_page_out, .rd_offset_out, .rd_bank_out,
		.rd_data_in, .data_out, .data_valid_out, .data_ready_in, .busy_out, .done_out, .reserved_page_out);
	mprb_store_model store (.page_in(rd_page_out), .offset_in(rd_offset_out), .bank_in(rd_bank_out),
		.data_out(rd_data_in));

	// free-running 50 MHz clock
	initial
		forever #10 mclk_in = ~mclk_in;

	task automatic check(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e)
		begin
			errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask : check

	// expected stream built from the page map; the bank follows the value-set choice
	task automatic expect_pages(input logic [1:0] sel, input logic [5:0] code, input logic [7:0] alloc);
		logic [1:0] bank;
		logic [7:0] len;
		exp.delete();
		bank = (sel == 2'h1) ? 2'h1 : (sel == 2'h2) ? 2'h2 : (sel == 2'h0 && ms_seen) ? 2'h0 :
			(saving_avail_in && saved_valid_in) ? 2'h3 : 2'h2;
		for (int i = 0; i < 10; i++)
			if (code == 6'h3f || code == mprb_pkg::PG_CODE[i])
			begin
				len = (sel == 2'h1) ? mprb_pkg::LEN_MASK[i] : mprb_pkg::LEN_VAL[i];
				exp.push_back({page_savable_in[i], 1'b0, mprb_pkg::PG_CODE[i]});
				exp.push_back(len);
				for (int k = 0; k < len; k++)
					exp.push_back({bank, 1'b0, 5'(k)} ^ {mprb_pkg::PG_CODE[i], 2'h0});
			end
		while (exp.size() > alloc)
			exp.pop_back();
	endtask : expect_pages

	// one command; the sink stalls every other pair of cycles when asked, so bytes must hold
	task automatic run(input logic [1:0] sel, input logic [5:0] code, input logic [7:0] alloc);
		int n;
		expect_pages(sel, code, alloc);
		got.delete();
		cdb_byte2_in <= {sel, code};
		alloc_len_in <= alloc;
		start_in <= 1'b1;
		@(posedge mclk_in);
		start_in <= 1'b0;
		for (n = 0; n < 2000 && done_out !== 1'b1; n++)
		begin
			@(posedge mclk_in);
			if (n == 0)
				check({7'h00, busy_out}, 8'h01);
			if (data_valid_out === 1'b1 && data_ready_in === 1'b1)
				got.push_back(data_out);
			data_ready_in <= !stall || n[1];
		end
		check({6'h00, busy_out, done_out}, 8'h01);
		check(8'(got.size()), 8'(exp.size()));
		foreach (exp[j])
			check(got[j], exp[j]);
	endtask : run

	task automatic t_single;
		stall = 1'b1;
		run(2'h2, 6'h0a, 8'hff);
		stall = 1'b0;
		$display("test single page done");
	endtask : t_single

	task automatic t_current;
		saving_avail_in <= 1'b1;
		saved_valid_in <= 1'b1;
		@(posedge mclk_in);
		run(2'h0, 6'h01, 8'hff);
		run(2'h3, 6'h1a, 8'hff);
		saved_valid_in <= 1'b0;
		@(posedge mclk_in);
		run(2'h0, 6'h01, 8'hff);
		run(2'h3, 6'h1a, 8'hff);
		mode_select_ok_in <= 1'b1;
		@(posedge mclk_in);
		mode_select_ok_in <= 1'b0;
		ms_seen = 1'b1;
		run(2'h0, 6'h20, 8'hff);
		$display("test current value choice done");
	endtask : t_current

	task automatic t_limits;
		run(2'h0, 6'h3f, 8'h05);
		run(2'h0, 6'h3f, 8'h00);
		$display("test allocation limits done");
	endtask : t_limits

	task automatic t_reserved;
		run(2'h0, 6'h05, 8'hff);
		check({7'h00, reserved_page_out}, 8'h01);
		run(2'h2, 6'h21, 8'hff);
		check({7'h00, reserved_page_out}, 8'h00);
		$display("test reserved codes done");
	endtask : t_reserved

	task automatic t_all;
		for (int s = 0; s < 4; s++)
			run(2'(s), 6'h3f, 8'hff);
		$display("test all pages done");
	endtask : t_all

	task automatic close_out;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	// main sequence: reset held five cycles, then the scenarios
	initial
	begin
		repeat (5) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		t_single();
		t_current();
		t_limits();
		t_reserved();
		t_all();
		close_out();
	end

	// watchdog well past the expected several hundred cycles
	initial
	begin
		#1ms;
		errors++;
		close_out();
	end
endmodule : mprb_top_tb
`default_nettype wire
